// [design/tdhc_capture.sv]
// Link status flags and HDLC channel capture with an APB register slave
// How it works
// RL1 - Sticky per-link flags record occurrences since read
// RL2 - Sixteen links, each with own status set
// RL3 - Signal loss sets loss flag
// RL4 - All-ones line input sets alarm flag
// RL5 - Line coding violation sets violation flag
// RL6 - Recovery FIFO overflow sets limit flag
// RL7 - Cable loss reported in whole decibels
// RL8 - Framer received zero and one flags
// RL9 - Framer transmitted zero and one flags
// RL10 - CRC error flag, only on E1 CRC links
// RL11 - Framer all-ones payload sets alarm flag
// RL12 - Frame structure error sets framing flag
// RL13 - Cell delineation loss sets its flag
// RL14 - Locked indication follows framer synchronisation
// RL15 - Normal connections numbered from 16, 496 maximum
// RL16 - Normal connections destuffed, 0x7E delimits packets
// RL17 - Raw connections numbered 0-15, never destuffed
// RL18 - Records typed 5, 6 or 8 by class
// RL19 - Sub-channels of 1, 2 or 4 bits
// RL20 - Hyper-channels gather timeslots of one link; map writes accept any link for a connection
// RL21 - Reading clears sticky bits unless still present
// RL22 - Entries carry direction, link, timeslot, bit mask
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "tdhc_params.svh"

module tdhc_capture #(
  parameter int NLINK = 16,
  parameter int NTS   = 32,
  parameter int NRAW  = `TDHC_NRAW,
  parameter int NNORM = `TDHC_NNORM
) (
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave
  input  wire logic [11:0]                paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output logic                            pready,
  output logic [31:0]                     prdata,
  output logic                            pslverr,
  // Line interface unit and framer status pins
  input  wire tdhc_pkg::tdhc_link_s [NLINK-1:0] link_stat_in,
  input  wire logic [NLINK-1:0][5:0]      cable_loss_in,
  // Received timeslot bits from the framers
  input  wire logic                       tdm_valid,
  input  wire tdhc_pkg::tdhc_tdm_s        tdm_in,
  // Captured record bytes
  output logic                            rec_valid,
  output tdhc_pkg::tdhc_rec_s             rec_out
);

  localparam int NCONN = NRAW + NNORM;
  localparam int NMAP  = NLINK * NTS;

  // Register state
  logic [NLINK-1:0]        crc_en_q, crc_en_d;
  logic [4:0]              raw_cnt_q, raw_cnt_d;
  logic [8:0]              norm_cnt_q, norm_cnt_d;
  tdhc_pkg::tdhc_id_t      last_id_q, last_id_d;
  logic [31:0]             prdata_q, prdata_d;
  logic [11:0]             sticky_q [NLINK];
  logic [31:0]             stat_w [NLINK];
  tdhc_pkg::tdhc_map_s     map_q [NMAP];
  tdhc_pkg::tdhc_attr_s    attr_q [NCONN];
  tdhc_pkg::tdhc_cst_s     cst_q [NCONN];
  tdhc_pkg::tdhc_rec_s     rec_q, rec_d;
  logic                    rec_v_q, rec_v_d;

  // Bus decode
  logic                    setup_rd, acc_rd, acc_wr;
  logic                    stat_sel;
  logic [3:0]              stat_idx;
  logic                    mapped;

  // Table write controls
  logic                    add_we, del_we, map_we, bad_wr;
  tdhc_pkg::tdhc_id_t      add_id, del_id;
  tdhc_pkg::tdhc_attr_s    add_attr;
  logic [8:0]              map_idx;
  tdhc_pkg::tdhc_map_s     map_new;

  // Datapath controls
  logic                    hit;
  tdhc_pkg::tdhc_id_t      hit_id;
  tdhc_pkg::tdhc_cst_s     cst_d;

  // Sub-channel masks: 1, 2 or 4 adjacent bits, or a whole timeslot
  function automatic logic mask_ok(input logic [7:0] m);
    logic [7:0] low;
    logic [3:0] n;
    low = m & 8'(~m + 8'h01);
    n = 4'($countones(m));
    mask_ok = (8'(m + low) & m) == 8'h00 &&
              (n == 4'h1 || n == 4'h2 || n == 4'h4 || n == 4'h8);
  endfunction : mask_ok

  // Address decode and strobes
  always_comb
  begin
    setup_rd = psel & ~penable & ~pwrite;
    acc_rd   = psel & penable & ~pwrite;
    acc_wr   = psel & penable & pwrite;
    stat_sel = paddr[11:6] == 6'h00;
    stat_idx = paddr[5:2];
    mapped   = stat_sel || paddr == `TDHC_CRC_EN ||
               paddr == `TDHC_CONN_ADD || paddr == `TDHC_CONN_DEL ||
               paddr == `TDHC_MAP || paddr == `TDHC_COUNTS;
  end

  // Per-link synchronisers, sticky flags and status words
  for (genvar gi = 0; gi < NLINK; gi++)
  begin : g_link
    tdhc_pkg::tdhc_link_s s1_q, s2_q;
    logic [5:0]           l1_q, l2_q;
    tdhc_pkg::tdhc_evt_s  ev;
    logic [11:0]          clr;
    logic [11:0]          sticky_d;

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        s1_q <= '0;
        s2_q <= '0;
        l1_q <= 6'h00;
        l2_q <= 6'h00;
      end
      else
      begin
        s1_q <= link_stat_in[gi];
        s2_q <= s1_q;
        l1_q <= cable_loss_in[gi];
        l2_q <= l1_q;
      end
    end

    // Set wins; a read clears only the bits it reported
    always_comb
    begin
      ev = s2_q.evt; // RL3 RL4 RL5 RL6 RL8 RL9 RL11 RL12 RL13
      ev.crc_err = s2_q.evt.crc_err & crc_en_q[gi]; // RL10
      clr = (acc_rd && stat_sel && stat_idx == 4'(gi)) ?
            prdata_q[11:0] : 12'h000; // RL21
      sticky_d = (sticky_q[gi] & ~clr) | ev; // RL1 RL2
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        sticky_q[gi] <= 12'h000;
      else
        sticky_q[gi] <= sticky_d;
    end

    // Live lock and cable loss beside the sticky bits
    always_comb
    begin
      stat_w[gi] = 32'h0000_0000;
      stat_w[gi][11:0] = sticky_q[gi];
      stat_w[gi][`TDHC_UP_BIT] = s2_q.locked; // RL14
      stat_w[gi][`TDHC_CLOSS_LSB +: 6] = l2_q; // RL7
    end
  end

  // Register writes and connection allocation
  always_comb
  begin
    crc_en_d   = crc_en_q;
    raw_cnt_d  = raw_cnt_q;
    norm_cnt_d = norm_cnt_q;
    last_id_d  = last_id_q;
    add_we     = 1'h0;
    del_we     = 1'h0;
    map_we     = 1'h0;
    bad_wr     = 1'h0;
    add_id     = '0;
    del_id     = pwdata[8:0];
    add_attr   = '0;
    map_idx    = 9'({pwdata[`TDHC_MAP_LINK_LSB +: 4],
                     pwdata[`TDHC_MAP_TS_LSB +: 5]});
    map_new.valid = pwdata[`TDHC_MAP_VALID];
    map_new.id    = pwdata[`TDHC_MAP_ID_LSB +: 9];
    map_new.mask  = pwdata[`TDHC_MAP_MASK_LSB +: 8];
    add_attr.valid  = 1'h1;
    add_attr.raw    = pwdata[`TDHC_ADD_RAW];
    add_attr.framed = pwdata[`TDHC_ADD_RAW] & pwdata[`TDHC_ADD_FRAMED];
    add_attr.tx     = pwdata[`TDHC_ADD_TX]; // RL22
    if (acc_wr)
    begin
      case (paddr)
        `TDHC_CRC_EN:
          crc_en_d = pwdata[NLINK-1:0];
        `TDHC_CONN_ADD:
          if (add_attr.raw)
          begin
            // Raw connections take 0 to 15 in order
            if (raw_cnt_q < 5'(NRAW))
            begin
              add_we    = 1'h1;
              add_id    = 9'(raw_cnt_q); // RL17
              raw_cnt_d = raw_cnt_q + 5'h01;
              last_id_d = 9'(raw_cnt_q);
            end
            else
              bad_wr = 1'h1;
          end
          else if (norm_cnt_q < 9'(NNORM))
          begin
            // Normal connections take 16 upward in order
            add_we     = 1'h1;
            add_id     = 9'(NRAW) + norm_cnt_q; // RL15
            norm_cnt_d = norm_cnt_q + 9'h001;
            last_id_d  = 9'(NRAW) + norm_cnt_q;
          end
          else
            bad_wr = 1'h1; // RL15
        `TDHC_CONN_DEL:
          if (10'(del_id) < 10'(NCONN))
            del_we = 1'h1;
          else
            bad_wr = 1'h1;
        `TDHC_MAP:
          // RL19 RL20 RL22
          if (!map_new.valid ||
              (mask_ok(map_new.mask) && 10'(map_new.id) < 10'(NCONN) &&
               10'(map_idx) < 10'(NMAP)))
            map_we = 1'h1;
          else
            bad_wr = 1'h1;
        default:
          bad_wr = !mapped;
      endcase
    end
  end

  // Read data captured in the setup phase
  always_comb
  begin
    prdata_d = prdata_q;
    if (setup_rd)
    begin
      prdata_d = 32'h0000_0000;
      if (stat_sel)
        prdata_d = stat_w[stat_idx];
      else
      begin
        case (paddr)
          `TDHC_CRC_EN:   prdata_d[NLINK-1:0] = crc_en_q;
          `TDHC_CONN_ADD: prdata_d[8:0] = last_id_q;
          `TDHC_COUNTS:
          begin
            prdata_d[4:0] = raw_cnt_q;
            prdata_d[`TDHC_CNT_NORM_LSB +: 9] = norm_cnt_q;
          end
          default:        prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  // Bit processing for the connection owning this timeslot bit
  always_comb
  begin
    tdhc_pkg::tdhc_map_s  m;
    tdhc_pkg::tdhc_attr_s a;
    tdhc_pkg::tdhc_cst_s  c;
    logic                 b;
    logic [7:0]           h;
    m = map_q[9'({tdm_in.link, tdm_in.ts})];
    a = attr_q[m.id];
    c = cst_q[m.id];
    b = tdm_in.data;
    h = {c.hist[6:0], b};
    hit_id  = m.id;
    hit = tdm_valid && m.valid && m.mask[tdm_in.bitpos] &&
          a.valid && !a.tx; // RL19 RL20 RL22
    cst_d   = c;
    rec_v_d = 1'h0;
    rec_d   = rec_q;
    cst_d.hist = h;
    if (hit)
    begin
      rec_d.conn_id = m.id;
      rec_d.delim   = 1'h0;
      if (a.raw)
      begin
        // Raw data keeps every bit, stuffed or not
        cst_d.data = {b, c.data[7:1]}; // RL17
        cst_d.cnt  = c.cnt + 3'h1;
        if (c.cnt == 3'h7)
        begin
          rec_v_d     = 1'h1;
          rec_d.data  = {b, c.data[7:1]};
          rec_d.rtype = a.framed ? `TDHC_REC_RAW_FRAMED :
                                   `TDHC_REC_RAW_LINE; // RL18
        end
      end
      else if (h == `TDHC_FLAG)
      begin
        // Delimiter: partial byte dropped, marker record sent
        cst_d.cnt   = 3'h0;
        cst_d.ones  = 3'h0;
        rec_v_d     = 1'h1;
        rec_d.delim = 1'h1; // RL16
        rec_d.data  = `TDHC_FLAG;
        rec_d.rtype = `TDHC_REC_NORMAL; // RL18
      end
      else if (!b && c.ones == `TDHC_STUFF_RUN)
        cst_d.ones = 3'h0; // RL16
      else
      begin
        cst_d.ones = !b ? 3'h0 :
                     (c.ones == `TDHC_ONES_MAX) ? c.ones :
                     c.ones + 3'h1;
        cst_d.data = {b, c.data[7:1]};
        cst_d.cnt  = c.cnt + 3'h1;
        if (c.cnt == 3'h7)
        begin
          rec_v_d     = 1'h1;
          rec_d.data  = {b, c.data[7:1]};
          rec_d.rtype = `TDHC_REC_NORMAL; // RL18
        end
      end
    end
    // Output record only moves with a pulse
    if (!rec_v_d)
      rec_d = rec_q;
  end

  // Registers and tables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      crc_en_q   <= '0;
      raw_cnt_q  <= 5'h00;
      norm_cnt_q <= 9'h000;
      last_id_q  <= 9'h000;
      prdata_q   <= 32'h0000_0000;
      rec_q      <= '0;
      rec_v_q    <= 1'h0;
      for (int i = 0; i < NMAP; i++)
        map_q[i] <= '0;
      for (int i = 0; i < NCONN; i++)
      begin
        attr_q[i] <= '0;
        cst_q[i]  <= '0;
      end
    end
    else
    begin
      crc_en_q   <= crc_en_d;
      raw_cnt_q  <= raw_cnt_d;
      norm_cnt_q <= norm_cnt_d;
      last_id_q  <= last_id_d;
      prdata_q   <= prdata_d;
      rec_q      <= rec_d;
      rec_v_q    <= rec_v_d;
      if (map_we)
        map_q[map_idx] <= map_new;
      if (hit)
        cst_q[hit_id] <= cst_d;
      if (add_we)
      begin
        attr_q[add_id] <= add_attr;
        cst_q[add_id]  <= '0;
      end
      if (del_we)
        attr_q[del_id] <= '0;
    end
  end

  // Bus and record outputs
  assign pready    = 1'h1;
  assign prdata    = prdata_q;
  assign pslverr   = psel & penable & (!mapped | bad_wr);
  assign rec_valid = rec_v_q;
  assign rec_out   = rec_q;

endmodule : tdhc_capture

`default_nettype wire

// [design/tdhc_params.svh]
// Register offsets, field positions and constants of the capture block
`ifndef TDHC_PARAMS_SVH
`define TDHC_PARAMS_SVH
// Byte offsets on the register bus
`define TDHC_STAT_BASE      12'h000
`define TDHC_CRC_EN         12'h040
`define TDHC_CONN_ADD       12'h044
`define TDHC_CONN_DEL       12'h048
`define TDHC_MAP            12'h04C
`define TDHC_COUNTS         12'h050
// Link status word fields
`define TDHC_UP_BIT         12
`define TDHC_CLOSS_LSB      16
// Connection add word fields
`define TDHC_ADD_RAW        0
`define TDHC_ADD_FRAMED     1
`define TDHC_ADD_TX         2
// Map word fields
`define TDHC_MAP_ID_LSB     0
`define TDHC_MAP_LINK_LSB   9
`define TDHC_MAP_TS_LSB     13
`define TDHC_MAP_MASK_LSB   18
`define TDHC_MAP_VALID      26
// Counts word fields
`define TDHC_CNT_NORM_LSB   16
// Connection identifier ranges
`define TDHC_NRAW           16
`define TDHC_NNORM          496
// Record types
`define TDHC_REC_NORMAL     4'h5
`define TDHC_REC_RAW_LINE   4'h6
`define TDHC_REC_RAW_FRAMED 4'h8
// HDLC constants
`define TDHC_FLAG           8'h7E
`define TDHC_STUFF_RUN      3'h5
`define TDHC_ONES_MAX       3'h7
`endif

// [design/tdhc_pkg.sv]
// Types shared by the capture block and its bench
`default_nettype none
package tdhc_pkg;
  typedef logic [8:0] tdhc_id_t;
  typedef struct packed {
    logic los;
    logic ais;
    logic lcv;
    logic fifo_ovf;
    logic framer_saw_zero;
    logic framer_saw_one;
    logic framer_sent_zero;
    logic framer_sent_one;
    logic crc_err;
    logic frm_ais;
    logic frm_err;
    logic cell_loss;
  } tdhc_evt_s;
  typedef struct packed {
    tdhc_evt_s evt;
    logic      locked;
  } tdhc_link_s;
  typedef struct packed {
    logic [3:0] link;
    logic [4:0] ts;
    logic [2:0] bitpos;
    logic       data;
  } tdhc_tdm_s;
  typedef struct packed {
    tdhc_id_t   conn_id;
    logic [3:0] rtype;
    logic       delim;
    logic [7:0] data;
  } tdhc_rec_s;
  typedef struct packed {
    logic       valid;
    tdhc_id_t   id;
    logic [7:0] mask;
  } tdhc_map_s;
  typedef struct packed {
    logic valid;
    logic raw;
    logic framed;
    logic tx;
  } tdhc_attr_s;
  typedef struct packed {
    logic [2:0] ones;
    logic [7:0] hist;
    logic [7:0] data;
    logic [2:0] cnt;
  } tdhc_cst_s;
endpackage : tdhc_pkg
`default_nettype wire

// [verif/tdhc_capture_bench.sv]
// Self-checking bench of the capture block
`timescale 1ns/1ns
`default_nettype none
module tdhc_capture_bench;
  logic                        pclk, presetn, psel, penable, pwrite, er;
  logic                        pready, pslverr, tdm_valid, rec_valid;
  logic [11:0]                 paddr;
  logic [31:0]                 pwdata, prdata, rd, lfsr;
  logic [15:0][5:0]            closs;
  tdhc_pkg::tdhc_link_s [15:0] lstat;
  tdhc_pkg::tdhc_tdm_s         tdm;
  tdhc_pkg::tdhc_rec_s         rec_out;
  tdhc_pkg::tdhc_rec_s         exp_q[$];
  int                          num_errors, comparisons, cyc;
  tdhc_capture u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .link_stat_in(lstat), .cable_loss_in(closs), .tdm_valid(tdm_valid),
    .tdm_in(tdm), .rec_valid(rec_valid), .rec_out(rec_out));
  tdhc_line_model u_m (.pclk(pclk), .link_stat(lstat),
    .cable_loss(closs), .tdm_valid(tdm_valid), .tdm(tdm));
  // Clock and cycle ceiling
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      results();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // Record watcher against the oldest note
  always @(posedge pclk)
    if (rec_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(32'(rec_out), 32'hFFFFFFFF);
      else
        chk(32'(rec_out), 32'(exp_q.pop_front()));
    end
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic ex(input logic [8:0] id, input logic [3:0] t,
                    input logic dl, input logic [7:0] d);
    exp_q.push_back({id, t, dl, d});
  endtask : ex
  // Bits LSB first, bit position cycling modulo m
  task automatic sendv(input logic [3:0] l, input logic [4:0] t,
                       input logic [31:0] v, input int n, input int m);
    for (int i = 0; i < n; i++)
      u_m.send(l, t, 3'(i % m), v[i]);
  endtask : sendv
  // Next value of the random source
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  function automatic logic [31:0] mw(input int id, input int l,
                                     input int t, input int m);
    return 32'(id + (l << 9) + (t << 13) + (m << 18) + (1 << 26));
  endfunction : mw
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {num_errors, comparisons, cyc} = '0;
    lfsr = 32'h15E0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 12'h040, 32'h0000FFFF);
    for (int b = 0; b < 12; b++)
    begin
      u_m.pulse(b, 12'(1 << b));
      repeat (4) @(posedge pclk);
      apb(1'b0, 12'(4 * b), 0);
      chk(rd, ((b + 3) << 16) | ((b & 1) << 12) | (1 << b));
      apb(1'b0, 12'(4 * b), 0);
      chk(rd, ((b + 3) << 16) | ((b & 1) << 12));
    end
    apb(1'b1, 12'h040, 0);
    u_m.pulse(3, 12'h008);
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h00C, 0);
    chk(rd, 32'h00061000);
    $display("test status done");
    apb(1'b1, 12'h044, 0);
    apb(1'b0, 12'h044, 0);
    chk(rd & 32'h1FF, 16);
    apb(1'b1, 12'h044, 1);
    apb(1'b0, 12'h044, 0);
    chk(rd & 32'h1FF, 0);
    apb(1'b1, 12'h044, 3);
    apb(1'b1, 12'h044, 4);
    apb(1'b0, 12'h044, 0);
    chk(rd & 32'h1FF, 17);
    apb(1'b0, 12'h050, 0);
    chk(rd & 32'h01FF001F, 32'h00020002);
    apb(1'b1, 12'h04C, mw(16, 2, 1, 255));
    apb(1'b1, 12'h04C, mw(0, 3, 4, 255));
    apb(1'b1, 12'h04C, mw(1, 4, 5, 15));
    apb(1'b1, 12'h04C, mw(17, 5, 6, 255));
    apb(1'b1, 12'h04C, mw(1, 4, 5, 5));
    chk(32'(er), 1);
    apb(1'b0, 12'h060, 0);
    chk(32'(er), 1);
    $display("test tables done");
    ex(16, 4'h5, 1'b1, 8'h7E);
    ex(16, 4'h5, 1'b0, 8'hFF);
    ex(16, 4'h5, 1'b1, 8'h7E);
    sendv(2, 1, 32'({8'h7E, 9'h1DF, 8'h7E}), 25, 8);
    ex(0, 4'h6, 1'b0, 8'h7E);
    sendv(3, 4, 32'h7E, 8, 8);
    lfsr = lfsr_next(lfsr);
    ex(1, 4'h8, 1'b0, lfsr[7:0]);
    u_m.send(4, 5, 3'h7, 1'b1);
    sendv(4, 5, lfsr, 8, 4);
    sendv(5, 6, lfsr, 8, 8);
    apb(1'b1, 12'h048, 16);
    sendv(2, 1, lfsr, 16, 8);
    repeat (4) @(posedge pclk);
    chk(32'(exp_q.size()), 0);
    $display("test stream done");
    results();
  end
endmodule : tdhc_capture_bench
bind tdhc_capture tdhc_capture_props u_props (.pclk(pclk),
  .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pslverr(pslverr), .tdm_valid(tdm_valid), .rec_valid(rec_valid),
  .rec_out(rec_out));
`default_nettype wire

// [verif/tdhc_capture_properties.sv]
// Port checker of the capture block
`timescale 1ns/1ns
`default_nettype none
module tdhc_capture_props (
  // Clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // Register bus
  input wire logic [11:0]         paddr,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pslverr,
  // Record stream
  input wire logic                tdm_valid,
  input wire logic                rec_valid,
  input wire tdhc_pkg::tdhc_rec_s rec_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Steps of a bus access and of a record
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_rec;
    rec_valid;
  endsequence
  // Record fields tied to connection class
  a_rec_type: assert property (s_rec |->
    rec_out.rtype inside {4'h5, 4'h6, 4'h8}) else $error("bad type");
  a_raw_id: assert property (s_rec ##0 (rec_out.rtype != 4'h5) |->
    rec_out.conn_id < 9'h010) else $error("raw id range");
  a_norm_id: assert property (s_rec ##0 (rec_out.rtype == 4'h5) |->
    rec_out.conn_id >= 9'h010) else $error("normal id range");
  a_flag_byte: assert property (s_rec ##0 rec_out.delim |->
    rec_out.data == 8'h7E && rec_out.rtype == 4'h5) else $error("delim");
  // Records follow a taken bit by one cycle and hold between pulses
  a_rec_cause: assert property (s_rec |-> $past(tdm_valid))
    else $error("record without bit");
  a_rec_hold: assert property (!rec_valid |-> $stable(rec_out))
    else $error("record moved");
  // Status words answer cleanly, unmapped places refuse
  a_stat_ok: assert property (s_acc ##0 (paddr < 12'h040) |->
    !pslverr) else $error("status refused");
  a_bad_addr: assert property (s_acc ##0 (paddr > 12'h050) |->
    pslverr) else $error("unmapped accepted");
endmodule : tdhc_capture_props
`default_nettype wire

// [verif/tdhc_line_model.sv]
// Line interface unit and framer stand-in
`timescale 1ns/1ns
`default_nettype none
module tdhc_line_model (
  // Clock
  input wire logic                  pclk,
  // Status levels and cable loss
  output tdhc_pkg::tdhc_link_s [15:0] link_stat,
  output logic [15:0][5:0]          cable_loss,
  // Timeslot bits
  output logic                      tdm_valid,
  output tdhc_pkg::tdhc_tdm_s       tdm
);
  // Lock on odd links, fixed loss per link
  initial
  begin
    tdm_valid = 1'b0;
    tdm = '0;
    for (int i = 0; i < 16; i++)
    begin
      link_stat[i] = '0;
      link_stat[i].locked = i[0];
      cable_loss[i] = 6'(i + 3);
    end
  end
  // Event levels held three cycles
  task automatic pulse(input int l, input logic [11:0] e);
    @(posedge pclk);
    link_stat[l].evt <= e;
    repeat (3) @(posedge pclk);
    link_stat[l].evt <= '0;
  endtask : pulse
  // One bit, then the data line flips
  task automatic send(input logic [3:0] l, input logic [4:0] t,
                      input logic [2:0] p, input logic d);
    @(posedge pclk);
    tdm_valid <= 1'b1;
    tdm <= '{l, t, p, d};
    @(posedge pclk);
    tdm_valid <= 1'b0;
    tdm.data <= ~d;
  endtask : send
endmodule : tdhc_line_model
`default_nettype wire
